// ---- sdlc_defines.svh ----
// Constants for the serial DAC load control block
`ifndef SDLC_DEFINES_SVH
`define SDLC_DEFINES_SVH
`define SDLC_CODE_W      12
`define SDLC_CODE_ZERO   12'h000
`define SDLC_CODE_MID    12'h800
`define SDLC_CODE_FULL   12'hFFF
`define SDLC_FIFO_DEPTH  4
`define SDLC_SYNC_RST    5'h0F
`endif

// ---- sdlc_fifo.sv ----
// Small valid/ready FIFO carrying completed shift words
`timescale 1ns/1ps
`default_nettype none
module sdlc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,    // System clock
  input  wire logic             rst,      // Async reset, active high
  input  wire logic             inValid,  // Write request
  output logic                  inReady,  // Room available
  input  wire logic [WIDTH-1:0] inData,   // Write data
  output logic                  outValid, // Data available
  input  wire logic             outReady, // Read accept
  output logic      [WIDTH-1:0] outData   // Read data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
  } sdlc_fifo_s;
  sdlc_fifo_s st_r, st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doWr, doRd;

  assign inReady  = (st_r.count != (AW+1)'(DEPTH));
  assign outValid = (st_r.count != '0);
  assign outData  = mem[st_r.rdPtr];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_comb begin
    st_nxt = st_r;
    if (doWr) begin
      st_nxt.wrPtr = (st_r.wrPtr == AW'(DEPTH-1)) ? '0 : st_r.wrPtr + 1'b1;
    end
    if (doRd) begin
      st_nxt.rdPtr = (st_r.rdPtr == AW'(DEPTH-1)) ? '0 : st_r.rdPtr + 1'b1;
    end
    if (doWr && !doRd) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (doRd && !doWr) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (doWr) begin
      mem[st_r.wrPtr] <= inData;
    end
  end

  property p_noOverflow;
    @(posedge clock) disable iff (rst) st_r.count <= (AW+1)'(DEPTH);
  endproperty
  a_noOverflow: assert property (p_noOverflow) else $error("FIFO count overflow"); // R12
endmodule : sdlc_fifo
`default_nettype wire

// ---- sdlc_host_model.sv ----
// Behavioural host driving the three-wire link and the strobe pins
`timescale 1ns/1ps
`default_nettype none
module sdlc_host_model (
  input  wire logic clock,        // System clock
  output logic      sclk,         // Link clock, idle low between frames
  output logic      serialIn,     // Serial data
  output logic      select_n,     // Device select
  output logic      loadStrobe_n, // Load strobe
  output logic      clear_n       // Clear
);
  import sdlc_pkg::*;
  initial begin
    sclk = 1'b0;
    serialIn = 1'b0;
    select_n = 1'b1;
    loadStrobe_n = 1'b1;
    clear_n = 1'b1;
  end
  // select driven to selN, strobe left high, MSB first, 400 ns link period
  task automatic shiftBits(input sdlc_code_t v, input logic selN);
    @(posedge clock) select_n <= selN;
    for (int i = 11; i >= 0; i--) begin
      serialIn <= v[i];
      repeat (4) @(posedge clock);
      sclk <= 1'b1;
      repeat (4) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    select_n <= 1'b1;
    // Released data line shows no stale value
    serialIn <= ~serialIn;
  endtask : shiftBits
  // low pulses on clear and strobe
  task automatic lower(input logic clrLow, input logic ldLow, input int n);
    @(posedge clock);
    clear_n <= ~clrLow;
    loadStrobe_n <= ~ldLow;
    repeat (n) @(posedge clock);
    clear_n <= 1'b1;
    loadStrobe_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : lower
endmodule : sdlc_host_model
`default_nettype wire

// ---- sdlc_pkg.sv ----
// Types for the serial DAC load control block
`include "sdlc_defines.svh"
package sdlc_pkg;
  typedef logic [`SDLC_CODE_W-1:0] sdlc_code_t;
  // Serial link pins after synchronisation
  typedef struct packed {
    logic sclk;
    logic serialIn;
    logic select_n;
    logic loadStrobe_n;
    logic clear_n;
  } sdlc_pins_s;
endpackage : sdlc_pkg

// ---- sdlc_serial_dac_load_control.sv ----
// Serial DAC front end: shift register, FIFO and DAC code latch
// Operation
// R1 - Shift register kept apart from the 12-bit DAC register for preloading.
// R2 - Serial data accepted only while select is low.
// R3 - Load strobe low transfers shift contents to DAC register, unrelated to sclk.
// R4 - DAC register follows shift data while strobe low, holds while high.
// R5 - Host raises strobe before shifting; never clocks data with strobe low.
// R6 - Clear low at any time forces the DAC register to zero.
// R7 - DAC code is straight binary: 000 zero, 800 mid, FFF full scale.
// R8 - Rising sclk with select low, strobe and clear high shifts one bit.
// R9 - Select high blocks shifting but never affects the load strobe.
// R10 - Clear wins over the load strobe and holds the register at zero.
// R11 - Strobe falling edge updates the register; transparent until it rises.
// R12 - Twelve bits, MSB first; the last twelve shifted form the code.
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_defines.svh"
module sdlc_serial_dac_load_control #(
  parameter int CODE_W = `SDLC_CODE_W,
  parameter int DEPTH  = `SDLC_FIFO_DEPTH
) (
  input  wire logic              clock,         // System clock, 20 MHz
  input  wire logic              rst,           // Async reset, active high
  input  wire logic              sclk,          // Serial link clock pin
  input  wire logic              serialIn,      // Serial data pin
  input  wire logic              select_n,      // Device select, active low
  input  wire logic              loadStrobe_n,  // Load strobe, active low
  input  wire logic              clear_n,       // Clear, active low
  output logic      [CODE_W-1:0] analogOut,     // DAC code driving the ladder
  output logic      [CODE_W-1:0] shiftWord,     // Shift register contents
  output logic                   shiftFull,     // Twelve bits shifted since last load
  output logic                   fifoOverrun    // Completed word dropped, FIFO full
);
  import sdlc_pkg::*;

  typedef struct packed {
    sdlc_pins_s        sync1;
    sdlc_pins_s        sync2;
    logic              sclkPrev;
    logic [CODE_W-1:0] shift;
    logic [4:0]        bitCount;
    logic [CODE_W-1:0] dacCode;
    logic              strobePrev;
    logic              overrun;
    logic              wordDone;
  } sdlc_state_s;

  sdlc_state_s st_r, st_nxt;
  sdlc_pins_s  pinsRaw;
  logic        sclkRise;
  logic        shiftEn;
  logic        pushValid;
  logic        pushReady;
  logic        popValid;
  logic        popReady;
  logic [CODE_W-1:0] popData;

  // Decodes the condition under which a link edge may shift
  function automatic logic shiftAllowed(input sdlc_pins_s p);
    return !p.select_n && p.loadStrobe_n && p.clear_n;
  endfunction : shiftAllowed

  // Decodes a strobe that clear does not override
  function automatic logic strobeOpen(input sdlc_pins_s p);
    return !p.loadStrobe_n && p.clear_n;
  endfunction : strobeOpen

  assign pinsRaw = '{sclk: sclk, serialIn: serialIn, select_n: select_n,
                     loadStrobe_n: loadStrobe_n, clear_n: clear_n};

  assign sclkRise = st_r.sync2.sclk && !st_r.sclkPrev;
  // R8 gated shift edge
  assign shiftEn  = sclkRise && shiftAllowed(st_r.sync2);

  // A completed word enters the FIFO on the twelfth shifted bit
  assign pushValid = shiftEn && (st_r.bitCount == 5'(CODE_W - 1));
  // The DAC latch drains one word per cycle of strobe low with clear high; otherwise the FIFO holds
  assign popReady  = strobeOpen(st_r.sync2);

  sdlc_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock    (clock),
    .rst      (rst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   ({st_r.shift[CODE_W-2:0], st_r.sync2.serialIn}),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popData)
  );

  always_comb begin
    st_nxt            = st_r;
    st_nxt.sync1      = pinsRaw;
    st_nxt.sync2      = st_r.sync1;
    st_nxt.sclkPrev   = st_r.sync2.sclk;
    st_nxt.strobePrev = st_r.sync2.loadStrobe_n;
    // R2 shift only with select low; R9 select never touches the strobe path
    if (shiftEn) begin
      // R12 MSB first shift
      st_nxt.shift = {st_r.shift[CODE_W-2:0], st_r.sync2.serialIn};
      // Count wraps per word so every twelfth bit offers a word to the FIFO, dropped if it is full
      if (st_r.bitCount == 5'(CODE_W - 1)) begin
        st_nxt.bitCount = 5'h00;
        st_nxt.wordDone = 1'b1;
      end else begin
        st_nxt.bitCount = st_r.bitCount + 5'h01;
      end
    end
    if (pushValid && !pushReady) begin
      st_nxt.overrun = 1'b1;
    end
    // R10 clear has priority
    if (!st_r.sync2.clear_n) begin
      // R6 force zero code
      st_nxt.dacCode = `SDLC_CODE_ZERO;
    end else if (strobeOpen(st_r.sync2)) begin
      // R4 transparent while strobe low; R11 update on falling edge
      // R3 transfer independent of the link clock
      if (popValid) begin
        st_nxt.dacCode = popData;
      end else begin
        st_nxt.dacCode = st_r.shift;
      end
      st_nxt.bitCount = 5'h00;
      st_nxt.wordDone = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r            <= '0;
      // Pins idle: link clock low, so no false edge follows reset
      st_r.sync1      <= `SDLC_SYNC_RST;
      st_r.sync2      <= `SDLC_SYNC_RST;
      st_r.strobePrev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // R1 separate registers; R7 straight binary code drives the ladder unchanged
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      analogOut   <= `SDLC_CODE_ZERO;
      shiftWord   <= '0;
      shiftFull   <= 1'b0;
      fifoOverrun <= 1'b0;
    end else begin
      analogOut   <= st_nxt.dacCode;
      shiftWord   <= st_nxt.shift;
      shiftFull   <= st_nxt.wordDone;
      fifoOverrun <= st_nxt.overrun;
    end
  end

  property p_clearZero;
    @(posedge clock) disable iff (rst)
      !st_r.sync2.clear_n |=> (st_r.dacCode == '0) && (analogOut == '0);
  endproperty
  a_clearZero: assert property (p_clearZero) else $error("Clear did not zero code"); // R6

  property p_clearPriority;
    @(posedge clock) disable iff (rst)
      (!st_r.sync2.clear_n && !st_r.sync2.loadStrobe_n) |=> st_r.dacCode == '0;
  endproperty
  a_clearPriority: assert property (p_clearPriority) else $error("Strobe beat clear"); // R10

  property p_holdHigh;
    @(posedge clock) disable iff (rst)
      (st_r.sync2.loadStrobe_n && st_r.sync2.clear_n) |=> $stable(st_r.dacCode);
  endproperty
  a_holdHigh: assert property (p_holdHigh) else $error("Code moved with strobe high"); // R4

  property p_transparent;
    @(posedge clock) disable iff (rst)
      (!st_r.sync2.loadStrobe_n && st_r.sync2.clear_n && !popValid)
        |=> st_r.dacCode == $past(st_r.shift);
  endproperty
  a_transparent: assert property (p_transparent) else $error("Code not following shift"); // R11

  property p_shiftStep;
    @(posedge clock) disable iff (rst)
      shiftEn |=> st_r.shift == {$past(st_r.shift[CODE_W-2:0]), $past(st_r.sync2.serialIn)};
  endproperty
  a_shiftStep: assert property (p_shiftStep) else $error("Shift step wrong"); // R8

  property p_selectBlocks;
    @(posedge clock) disable iff (rst)
      st_r.sync2.select_n |=> $stable(st_r.shift);
  endproperty
  a_selectBlocks: assert property (p_selectBlocks) else $error("Shift while deselected"); // R2

  property p_selectNoStrobe;
    @(posedge clock) disable iff (rst)
      (st_r.sync2.select_n && !st_r.sync2.loadStrobe_n && st_r.sync2.clear_n && !popValid)
        |=> st_r.dacCode == $past(st_r.shift);
  endproperty
  a_selectNoStrobe: assert property (p_selectNoStrobe) else $error("Select blocked load"); // R9

  property p_outFollows;
    @(posedge clock) disable iff (rst)
      1'b1 |=> analogOut == $past(st_nxt.dacCode);
  endproperty
  a_outFollows: assert property (p_outFollows) else $error("Output lags code"); // R7

  property p_wordPush;
    @(posedge clock) disable iff (rst)
      (pushValid && pushReady) |=> popValid;
  endproperty
  a_wordPush: assert property (p_wordPush) else $error("Twelfth bit lost word"); // R12

  property p_strobeFall;
    @(posedge clock) disable iff (rst)
      (st_r.strobePrev && !st_r.sync2.loadStrobe_n && st_r.sync2.clear_n)
        |=> st_r.dacCode == ($past(popValid) ? $past(popData) : $past(st_r.shift));
  endproperty
  a_strobeFall: assert property (p_strobeFall) else $error("Strobe fall missed update"); // R11

  property p_fifoDrain;
    @(posedge clock) disable iff (rst)
      (!st_r.sync2.loadStrobe_n && st_r.sync2.clear_n && popValid)
        |=> st_r.dacCode == $past(popData);
  endproperty
  a_fifoDrain: assert property (p_fifoDrain) else $error("Queued word not applied"); // R4

  property p_strobeNoShift;
    @(posedge clock) disable iff (rst)
      !st_r.sync2.loadStrobe_n |=> $stable(st_r.shift);
  endproperty
  a_strobeNoShift: assert property (p_strobeNoShift) else $error("Shift with strobe low"); // R8

  property p_clearNoShift;
    @(posedge clock) disable iff (rst)
      !st_r.sync2.clear_n |=> $stable(st_r.shift);
  endproperty
  a_clearNoShift: assert property (p_clearNoShift) else $error("Shift with clear low"); // R8

  property p_edgeOnly;
    @(posedge clock) disable iff (rst)
      !sclkRise |=> $stable(st_r.shift);
  endproperty
  a_edgeOnly: assert property (p_edgeOnly) else $error("Shift without link edge"); // R8

  property p_deselectCount;
    @(posedge clock) disable iff (rst)
      (st_r.sync2.select_n && st_r.sync2.loadStrobe_n) |=> $stable(st_r.bitCount);
  endproperty
  a_deselectCount: assert property (p_deselectCount) else $error("Count moved deselected"); // R2

  property p_preload;
    @(posedge clock) disable iff (rst)
      shiftEn |=> $stable(st_r.dacCode) && $stable(analogOut);
  endproperty
  a_preload: assert property (p_preload) else $error("Shift disturbed output code"); // R1

  property p_countRange;
    @(posedge clock) disable iff (rst)
      st_r.bitCount < 5'(CODE_W);
  endproperty
  a_countRange: assert property (p_countRange) else $error("Bit count out of range"); // R12

  property p_fullOnPush;
    @(posedge clock) disable iff (rst)
      pushValid |=> shiftFull;
  endproperty
  a_fullOnPush: assert property (p_fullOnPush) else $error("Full flag missing"); // R12

  property p_fullClear;
    @(posedge clock) disable iff (rst)
      (!st_r.sync2.loadStrobe_n && st_r.sync2.clear_n)
        |=> !shiftFull && (st_r.bitCount == 5'h00);
  endproperty
  a_fullClear: assert property (p_fullClear) else $error("Strobe left word count"); // R3

  property p_overrunSet;
    @(posedge clock) disable iff (rst)
      (pushValid && !pushReady) |=> fifoOverrun;
  endproperty
  a_overrunSet: assert property (p_overrunSet) else $error("Dropped word not flagged"); // R12

  property p_overrunSticky;
    @(posedge clock) disable iff (rst)
      fifoOverrun |=> fifoOverrun;
  endproperty
  a_overrunSticky: assert property (p_overrunSticky) else $error("Overrun flag lost"); // R12

  property p_pushHead;
    @(posedge clock) disable iff (rst)
      (pushValid && pushReady && !popValid)
        |=> popData == $past({st_r.shift[CODE_W-2:0], st_r.sync2.serialIn});
  endproperty
  a_pushHead: assert property (p_pushHead) else $error("Queued word differs"); // R12

  property p_analogHold;
    @(posedge clock) disable iff (rst)
      (st_r.sync2.loadStrobe_n && st_r.sync2.clear_n) |=> $stable(analogOut);
  endproperty
  a_analogHold: assert property (p_analogHold) else $error("Output moved strobe high"); // R4

  property p_deselectWord;
    @(posedge clock) disable iff (rst)
      st_r.sync2.select_n |=> $stable(shiftWord);
  endproperty
  a_deselectWord: assert property (p_deselectWord) else $error("Word moved deselected"); // R9
endmodule : sdlc_serial_dac_load_control
`default_nettype wire

// ---- sdlc_testbench.sv ----
// Self-checking bench for the serial DAC load control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdlc_pkg::*;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       sclk, serialIn, select_n, loadStrobe_n, clear_n;
  sdlc_code_t analogOut, shiftWord;
  logic       shiftFull, fifoOverrun;
  int         nMismatch = 0;
  int         comparisons = 0;
  always #25 clock = ~clock;
  sdlc_host_model sdlc_host_model_inst (.clock(clock), .sclk(sclk), .serialIn(serialIn),
    .select_n(select_n), .loadStrobe_n(loadStrobe_n), .clear_n(clear_n));
  sdlc_serial_dac_load_control #(.CODE_W(12), .DEPTH(4)) sdlc_serial_dac_load_control_inst (
    .clock(clock), .rst(rst), .sclk(sclk), .serialIn(serialIn), .select_n(select_n),
    .loadStrobe_n(loadStrobe_n), .clear_n(clear_n), .analogOut(analogOut),
    .shiftWord(shiftWord), .shiftFull(shiftFull), .fifoOverrun(fifoOverrun));
  task automatic tally_and_finish();
    if (nMismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Bounded wait for the code latch to settle
  task automatic waitCode(input sdlc_code_t exp);
    int k;
    k = 0;
    while (analogOut !== exp && k < 20) begin
      @(posedge clock);
      k++;
    end
    check(analogOut, exp);
    if (k == 20) tally_and_finish();
  endtask : waitCode
  // Preload keeps the old code, strobe transfers it
  task automatic codesScenario();
    sdlc_code_t codes [4] = '{12'h000, 12'h800, 12'hFFF, 12'hA5C};
    sdlc_code_t prev;
    foreach (codes[i]) begin
      prev = analogOut;
      sdlc_host_model_inst.shiftBits(codes[i], 1'b0);
      check(shiftWord, codes[i]);
      check({11'h000, shiftFull}, 12'h001);
      check(analogOut, prev);
      sdlc_host_model_inst.lower(1'b0, 1'b1, 8);
      waitCode(codes[i]);
      check({11'h000, shiftFull}, 12'h000);
    end
  endtask : codesScenario
  // Deselected shifting is ignored, strobe still works
  task automatic selectScenario();
    sdlc_host_model_inst.shiftBits(12'h3C5, 1'b0);
    sdlc_host_model_inst.shiftBits(12'h0F0, 1'b1);
    check(shiftWord, 12'h3C5);
    sdlc_host_model_inst.lower(1'b0, 1'b1, 8);
    waitCode(12'h3C5);
    check({11'h000, fifoOverrun}, 12'h000);
  endtask : selectScenario
  // Clear alone and clear against a low strobe
  task automatic clearScenario();
    sdlc_host_model_inst.lower(1'b1, 1'b0, 8);
    waitCode(12'h000);
    sdlc_host_model_inst.shiftBits(12'h7FF, 1'b0);
    fork
      sdlc_host_model_inst.lower(1'b1, 1'b1, 12);
      begin
        repeat (10) @(posedge clock);
        check(analogOut, 12'h000);
      end
    join
    repeat (6) @(posedge clock);
    check(analogOut, 12'h000);
  endtask : clearScenario
  // Five unloaded words overrun the four-deep queue
  task automatic fifoScenario();
    for (int i = 1; i <= 5; i++) begin
      sdlc_host_model_inst.shiftBits(12'h100 * i[11:0] + 12'h001, 1'b0);
    end
    check({11'h000, fifoOverrun}, 12'h001);
    sdlc_host_model_inst.lower(1'b0, 1'b1, 20);
    waitCode(12'h501);
  endtask : fifoScenario
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    check(analogOut, 12'h000);
    codesScenario();
    selectScenario();
    clearScenario();
    fifoScenario();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
